// >>> status_share_bus_defines.svh
// register addresses, field positions, masks and codes of the status sharing bus
`ifndef STATUS_SHARE_BUS_DEFINES_SVH
`define STATUS_SHARE_BUS_DEFINES_SVH

// register addresses
`define ADDR_CTRL_ONE 8'hB0
`define ADDR_CTRL_TWO 8'hB1
`define ADDR_INFO_IRQ 8'hB2
`define ADDR_INFO_SYNC 8'hB3
`define ADDR_INFO_USER_ONE 8'hB4
`define ADDR_INFO_USER_TWO 8'hB5

// reset value and writable bits
`define REG_RESET 8'h00
`define CTRL_ONE_MASK 8'h0F
`define CTRL_TWO_MASK 8'h77
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hFF

// field positions
`define C1_ENABLE_BIT 0
`define C1_LINE_SEL_LSB 1
`define C1_LINE_SEL_MSB 3
`define C2_STAT3_LSB 0
`define C2_STAT3_MSB 2
`define C2_STAT4_LSB 4
`define C2_STAT4_MSB 6

// status selection codes
`define STAT_BOC_UA1 3'h0
`define STAT_YEL_RA 3'h1
`define STAT_LUP_DMA 3'h2
`define STAT_LDN_V52 3'h3
`define STAT_SIGNALING_CHANGE 3'h4
`define STAT_SLIP 3'h5

`endif

// >>> status_share_bus_pkg.sv
// types shared by the status sharing bus logic
`default_nettype none
package status_share_bus_pkg;
	// alarm and event inputs from the transceiver
	typedef struct packed {
		logic bit_oriented_code_seen;
		logic unframed_all_ones;
		logic yellow_alarm;
		logic remote_alarm;
		logic loop_up_code;
		logic distant_multiframe_alarm;
		logic loop_down_code;
		logic v52_link_detect;
		logic signaling_change;
		logic elastic_store_slip;
	} alarm_in_t;

	// which information register a group read asks for
	typedef enum logic [1:0] {
		VIEW_IRQ = 2'b00,
		VIEW_SYNC_LOSS = 2'b01,
		VIEW_USER_ONE = 2'b10,
		VIEW_USER_TWO = 2'b11
	} info_view_t;
endpackage : status_share_bus_pkg
`default_nettype wire

// >>> status_share_bus.sv
// status sharing bus member: control registers, group signalling and data line drive
//
// Overview of operation
// - one read of any member returns status bits of up to 8 ports
// - on information reads each enabled member drives one data bit only
// - two group sync lines and a read strobe carry reads to all members
// - control one bit 0 turns group participation on or off
// - control one bits 1 to 3 pick which data line n this member drives
// - control two bits 0 to 2 pick the status shown by information three
// - control two bits 4 to 6 pick the status shown by information four
// - information one read makes members show interrupt status
// - information two read makes members show sync loss status
// - information three read shows the first selected status
// - information four read shows the second selected status
`include "status_share_bus_defines.svh"
`default_nettype none
module status_share_bus #(
	parameter int unsigned DATA_W = 8
) (
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// host port
	input wire logic CS,
	input wire logic RD,
	input wire logic WR,
	input wire logic [7:0] ADDR,
	input wire logic [DATA_W-1:0] WDATA,
	output logic [DATA_W-1:0] HDATA_OUT,
	output logic [DATA_W-1:0] HDATA_OE,
	output logic RVALID,
	// transceiver status
	input wire logic E1_MODE,
	input wire logic MEMBER_IRQ_STATUS,
	input wire logic MEMBER_SYNC_LOSS,
	input wire status_share_bus_pkg::alarm_in_t ALARMS,
	// group signals
	input wire logic GROUP_SYNC_LINE_0_IN,
	input wire logic GROUP_SYNC_LINE_1_IN,
	input wire logic GROUP_READ_STROBE_IN,
	output logic GROUP_SYNC_LINE_0_OUT,
	output logic GROUP_SYNC_LINE_0_OE,
	output logic GROUP_SYNC_LINE_1_OUT,
	output logic GROUP_SYNC_LINE_1_OE,
	output logic GROUP_READ_STROBE_OUT,
	output logic GROUP_READ_STROBE_OE
);

	logic [7:0] ctrl_one_q;
	logic [7:0] ctrl_two_q;
	logic rd_pend_q;
	logic [7:0] rd_addr_q;
	logic host_rd;
	logic host_wr;
	logic local_info;
	logic part_en;
	logic [2:0] line_sel;
	logic own_info;
	logic peer_info;
	logic share;
	logic status_bit;
	status_share_bus_pkg::info_view_t view;
	logic [DATA_W-1:0] data_d;
	logic [DATA_W-1:0] oe_d;
	logic [DATA_W-1:0] line_hit;
	logic [1:0] req_code;

	// true for the four information register addresses
	function automatic logic is_info(input logic [7:0] a);
		is_info = (a >= `ADDR_INFO_IRQ) && (a <= `ADDR_INFO_USER_TWO);
	endfunction : is_info

	// information register address to view code
	function automatic status_share_bus_pkg::info_view_t info_index(input logic [7:0] a);
		logic [7:0] diff;
		diff = a - `ADDR_INFO_IRQ;
		info_index = status_share_bus_pkg::info_view_t'(diff[1:0]);
	endfunction : info_index

	// selectable status, encoding differs between T1 and E1
	function automatic logic pick_status(input logic [2:0] code, input logic e1,
			input status_share_bus_pkg::alarm_in_t al);
		pick_status = 1'b0;
		case (code)
			`STAT_BOC_UA1: pick_status = e1 ? al.unframed_all_ones : al.bit_oriented_code_seen;
			`STAT_YEL_RA: pick_status = e1 ? al.remote_alarm : al.yellow_alarm;
			`STAT_LUP_DMA: pick_status = e1 ? al.distant_multiframe_alarm : al.loop_up_code;
			`STAT_LDN_V52: pick_status = e1 ? al.v52_link_detect : al.loop_down_code;
			`STAT_SIGNALING_CHANGE: pick_status = al.signaling_change;
			`STAT_SLIP: pick_status = al.elastic_store_slip;
			default: pick_status = 1'b0; // undefined codes report zero
		endcase
	endfunction : pick_status

	// host strobes and decoded fields
	assign host_rd = CS && RD;
	assign host_wr = CS && WR && !RD;
	assign local_info = host_rd && is_info(ADDR);
	assign req_code = info_index(ADDR); // view code sent on the two sync lines
	assign part_en = ctrl_one_q[`C1_ENABLE_BIT];
	assign line_sel = ctrl_one_q[`C1_LINE_SEL_MSB:`C1_LINE_SEL_LSB];

	// control register one, unused bits kept at zero
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			ctrl_one_q <= `REG_RESET;
		end else if (host_wr && (ADDR == `ADDR_CTRL_ONE)) begin
			ctrl_one_q <= WDATA & `CTRL_ONE_MASK;
		end
	end

	// control register two, holds both status select fields
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			ctrl_two_q <= `REG_RESET;
		end else if (host_wr && (ADDR == `ADDR_CTRL_TWO)) begin
			ctrl_two_q <= WDATA & `CTRL_TWO_MASK;
		end
	end

	// read request stage, answer follows one cycle later
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= `REG_RESET;
		end else begin
			rd_pend_q <= host_rd;
			rd_addr_q <= ADDR;
		end
	end

	// group signalling, peers see the request in the same cycle as this member
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			GROUP_READ_STROBE_OUT <= 1'b0;
			GROUP_READ_STROBE_OE <= 1'b0;
			GROUP_SYNC_LINE_0_OUT <= 1'b0;
			GROUP_SYNC_LINE_0_OE <= 1'b0;
			GROUP_SYNC_LINE_1_OUT <= 1'b0;
			GROUP_SYNC_LINE_1_OE <= 1'b0;
		end else begin
			GROUP_READ_STROBE_OUT <= local_info && part_en;
			GROUP_READ_STROBE_OE <= local_info && part_en;
			GROUP_SYNC_LINE_0_OUT <= local_info && part_en && req_code[0];
			GROUP_SYNC_LINE_0_OE <= local_info && part_en;
			GROUP_SYNC_LINE_1_OUT <= local_info && part_en && req_code[1];
			GROUP_SYNC_LINE_1_OE <= local_info && part_en;
		end
	end

	// which view is answered, own request wins over a peer strobe
	always_comb begin
		own_info = rd_pend_q && is_info(rd_addr_q);
		peer_info = GROUP_READ_STROBE_IN && !rd_pend_q;
		share = part_en && (own_info || peer_info);
		if (own_info) begin
			view = info_index(rd_addr_q);
		end else begin
			view = status_share_bus_pkg::info_view_t'({GROUP_SYNC_LINE_1_IN, GROUP_SYNC_LINE_0_IN});
		end
	end

	// status bit for the requested view
	always_comb begin
		case (view)
			status_share_bus_pkg::VIEW_IRQ: status_bit = MEMBER_IRQ_STATUS;
			status_share_bus_pkg::VIEW_SYNC_LOSS: status_bit = MEMBER_SYNC_LOSS;
			status_share_bus_pkg::VIEW_USER_ONE: status_bit =
				pick_status(ctrl_two_q[`C2_STAT3_MSB:`C2_STAT3_LSB], E1_MODE, ALARMS);
			default: status_bit =
				pick_status(ctrl_two_q[`C2_STAT4_MSB:`C2_STAT4_LSB], E1_MODE, ALARMS);
		endcase
	end

	// one enable per data line, only the selected line matches
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi++) begin : g_line
			assign line_hit[gi] = (line_sel == 3'(gi));
		end
	endgenerate

	// data and enable for the answer cycle
	always_comb begin
		data_d = `BYTE_ZERO;
		oe_d = `BYTE_ZERO;
		if (share) begin
			oe_d = line_hit;
			data_d = status_bit ? line_hit : `BYTE_ZERO;
		end else if (rd_pend_q) begin
			oe_d = `BYTE_ONES;
			if (rd_addr_q == `ADDR_CTRL_ONE) begin
				data_d = ctrl_one_q;
			end else if (rd_addr_q == `ADDR_CTRL_TWO) begin
				data_d = ctrl_two_q;
			end else begin
				data_d = `BYTE_ZERO;
			end
		end
	end

	// host data outputs
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			HDATA_OUT <= `BYTE_ZERO;
			HDATA_OE <= `BYTE_ZERO;
			RVALID <= 1'b0;
		end else begin
			HDATA_OUT <= data_d;
			HDATA_OE <= oe_d;
			RVALID <= rd_pend_q;
		end
	end

	// checks
	a_ctrl_one_write: assert property (@(posedge CLK) disable iff (!NRST)
		host_wr && ADDR == `ADDR_CTRL_ONE |=> ctrl_one_q == ($past(WDATA) & `CTRL_ONE_MASK))
		else $error("control one not updated");
	a_ctrl_two_write: assert property (@(posedge CLK) disable iff (!NRST)
		host_wr && ADDR == `ADDR_CTRL_TWO |=> ctrl_two_q == ($past(WDATA) & `CTRL_TWO_MASK))
		else $error("control two not updated");
	a_strobe_sent: assert property (@(posedge CLK) disable iff (!NRST)
		local_info && part_en |=> GROUP_READ_STROBE_OE && GROUP_READ_STROBE_OUT
		&& {GROUP_SYNC_LINE_1_OUT, GROUP_SYNC_LINE_0_OUT} == 2'($past(ADDR) - `ADDR_INFO_IRQ))
		else $error("group strobe or code missing");
	a_one_answer: assert property (@(posedge CLK) disable iff (!NRST)
		local_info ##1 1'b1 |=> RVALID && HDATA_OE != `BYTE_ZERO)
		else $error("info read got no answer two cycles on");
	a_single_line: assert property (@(posedge CLK) disable iff (!NRST)
		share |=> $onehot(HDATA_OE))
		else $error("group answer drives other than one line");
	a_line_position: assert property (@(posedge CLK) disable iff (!NRST)
		share |=> HDATA_OE[$past(line_sel)])
		else $error("wrong data line driven");
	a_disabled_quiet: assert property (@(posedge CLK) disable iff (!NRST)
		GROUP_READ_STROBE_IN && !rd_pend_q && !part_en |=> HDATA_OE == `BYTE_ZERO)
		else $error("disabled member answered a peer read");
	a_irq_view: assert property (@(posedge CLK) disable iff (!NRST)
		share && view == status_share_bus_pkg::VIEW_IRQ
		|=> HDATA_OUT[$past(line_sel)] == $past(MEMBER_IRQ_STATUS))
		else $error("interrupt status wrong");
	a_sync_view: assert property (@(posedge CLK) disable iff (!NRST)
		share && view == status_share_bus_pkg::VIEW_SYNC_LOSS
		|=> HDATA_OUT[$past(line_sel)] == $past(MEMBER_SYNC_LOSS))
		else $error("sync loss status wrong");
	a_slip_view: assert property (@(posedge CLK) disable iff (!NRST)
		share && view == status_share_bus_pkg::VIEW_USER_ONE
		&& ctrl_two_q[`C2_STAT3_MSB:`C2_STAT3_LSB] == `STAT_SLIP
		|=> HDATA_OUT[$past(line_sel)] == $past(ALARMS.elastic_store_slip))
		else $error("first user status wrong");
	a_user_two_e1: assert property (@(posedge CLK) disable iff (!NRST)
		share && view == status_share_bus_pkg::VIEW_USER_TWO && E1_MODE
		&& ctrl_two_q[`C2_STAT4_MSB:`C2_STAT4_LSB] == `STAT_YEL_RA
		|=> HDATA_OUT[$past(line_sel)] == $past(ALARMS.remote_alarm))
		else $error("second user status wrong");
	a_undef_zero: assert property (@(posedge CLK) disable iff (!NRST)
		share && view == status_share_bus_pkg::VIEW_USER_ONE
		&& ctrl_two_q[`C2_STAT3_MSB:`C2_STAT3_LSB] > `STAT_SLIP
		|=> HDATA_OUT == `BYTE_ZERO)
		else $error("undefined select not zero");

	// group lines stay released while participation is off
	a_disabled_no_strobe: assert property (@(posedge CLK) disable iff (!NRST)
		!part_en |=> !GROUP_READ_STROBE_OE && !GROUP_SYNC_LINE_0_OE && !GROUP_SYNC_LINE_1_OE)
		else $error("disabled member sent group signals");
	// a disabled member still answers its own info read with a zero byte
	a_disabled_own_read: assert property (@(posedge CLK) disable iff (!NRST)
		own_info && !part_en |=> HDATA_OE == `BYTE_ONES && HDATA_OUT == `BYTE_ZERO)
		else $error("disabled own read answer wrong");
	// control one reads back its stored bits on the whole byte
	a_ctrl_read: assert property (@(posedge CLK) disable iff (!NRST)
		rd_pend_q && rd_addr_q == `ADDR_CTRL_ONE
		|=> HDATA_OE == `BYTE_ONES && HDATA_OUT == $past(ctrl_one_q))
		else $error("control one read back wrong");
	// further select codes in both line modes
	a_user_one_t1: assert property (@(posedge CLK) disable iff (!NRST)
		share && view == status_share_bus_pkg::VIEW_USER_ONE && !E1_MODE
		&& ctrl_two_q[`C2_STAT3_MSB:`C2_STAT3_LSB] == `STAT_BOC_UA1
		|=> HDATA_OUT[$past(line_sel)] == $past(ALARMS.bit_oriented_code_seen))
		else $error("first user status code zero wrong");
	a_user_one_e1: assert property (@(posedge CLK) disable iff (!NRST)
		share && view == status_share_bus_pkg::VIEW_USER_ONE && E1_MODE
		&& ctrl_two_q[`C2_STAT3_MSB:`C2_STAT3_LSB] == `STAT_LUP_DMA
		|=> HDATA_OUT[$past(line_sel)] == $past(ALARMS.distant_multiframe_alarm))
		else $error("first user status code two wrong");
	a_user_two_sig: assert property (@(posedge CLK) disable iff (!NRST)
		share && view == status_share_bus_pkg::VIEW_USER_TWO
		&& ctrl_two_q[`C2_STAT4_MSB:`C2_STAT4_LSB] == `STAT_SIGNALING_CHANGE
		|=> HDATA_OUT[$past(line_sel)] == $past(ALARMS.signaling_change))
		else $error("second user status code four wrong");

	// scenarios
	c_local_group_read: cover property (@(posedge CLK) disable iff (!NRST)
		local_info && part_en ##2 RVALID);
	c_peer_answer: cover property (@(posedge CLK) disable iff (!NRST)
		peer_info && part_en ##1 HDATA_OE != `BYTE_ZERO);
	c_disabled_own_read: cover property (@(posedge CLK) disable iff (!NRST)
		local_info && !part_en ##2 HDATA_OE == `BYTE_ONES);
	c_ctrl_write_read: cover property (@(posedge CLK) disable iff (!NRST)
		host_wr && ADDR == `ADDR_CTRL_ONE ##1 host_rd && ADDR == `ADDR_CTRL_ONE);
	c_undef_select: cover property (@(posedge CLK) disable iff (!NRST)
		share && view == status_share_bus_pkg::VIEW_USER_TWO
		&& ctrl_two_q[`C2_STAT4_MSB:`C2_STAT4_LSB] > `STAT_SLIP);

endmodule : status_share_bus
`default_nettype wire

// >>> status_share_peer.sv
// peer group member model: starts group reads and answers strobes on its own line
`default_nettype none
module status_share_peer (
	// clock
	input wire logic clk,
	// bench commands
	input wire logic go,
	input wire logic [1:0] code,
	input wire logic [2:0] line,
	input wire logic stat,
	// resolved group strobe
	input wire logic strobe_in,
	// group lines, driven only while high, pull-low otherwise
	output logic sync0,
	output logic sync1,
	output logic strobe,
	// host data drive
	output logic [7:0] data_out,
	output logic [7:0] data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// one-cycle group read with the view code on the two sync lines
	always_ff @(posedge clk) begin
		strobe <= go;
		sync0 <= go & code[0];
		sync1 <= go & code[1];
	end
	// answer any resolved strobe on one bit, never shared with the member
	always_ff @(posedge clk) begin
		data_oe <= strobe_in ? (8'h01 << line) : 8'h00;
		data_out <= strobe_in ? ({7'h00, stat} << line) : 8'h00;
	end
endmodule : status_share_peer
`default_nettype wire

// >>> status_share_bus_tb_top.sv
// self-checking bench for one status sharing bus member and a peer
`default_nettype none
module status_share_bus_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, nrst, cs, rd, wr, e1, irq, sl, go, pst, rv;
	logic s0o, s0e, s1o, s1e, sto, ste, ps0, ps1, pstb, s0, s1, stb;
	logic [7:0] addr, wdata, hout, hoe, pout, poe, hbus;
	logic [7:0] flt = 8'hA5;
	logic [1:0] pcode;
	logic [2:0] line;
	logic [3:0] gcode;
	status_share_bus_pkg::alarm_in_t al;
	int n_mismatch = 0;
	int compares = 0;
	// group wires pulled low, host bus floats to a toggling pattern
	assign s0 = (s0e & s0o) | ps0;
	assign s1 = (s1e & s1o) | ps1;
	assign stb = (ste & sto) | pstb;
	assign hbus = (hoe & hout) | (~hoe & poe & pout) | (~hoe & ~poe & flt);
	always @(posedge clk) flt <= ~flt;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	status_share_bus i_dut (.CLK(clk), .NRST(nrst), .CS(cs), .RD(rd), .WR(wr), .ADDR(addr),
		.WDATA(wdata), .HDATA_OUT(hout), .HDATA_OE(hoe), .RVALID(rv), .E1_MODE(e1),
		.MEMBER_IRQ_STATUS(irq), .MEMBER_SYNC_LOSS(sl), .ALARMS(al),
		.GROUP_SYNC_LINE_0_IN(s0), .GROUP_SYNC_LINE_1_IN(s1), .GROUP_READ_STROBE_IN(stb),
		.GROUP_SYNC_LINE_0_OUT(s0o), .GROUP_SYNC_LINE_0_OE(s0e),
		.GROUP_SYNC_LINE_1_OUT(s1o), .GROUP_SYNC_LINE_1_OE(s1e),
		.GROUP_READ_STROBE_OUT(sto), .GROUP_READ_STROBE_OE(ste));
	status_share_peer i_peer (.clk(clk), .go(go), .code(pcode), .line(line), .stat(pst),
		.strobe_in(stb), .sync0(ps0), .sync1(ps1), .strobe(pstb), .data_out(pout),
		.data_oe(poe));
	// compare one byte and count it
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// counts and verdict, then stop
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	// one host write, entered just after a rising edge
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		cs <= 1'b1;
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		cs <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus_wr
	// one host read; st tells whether the strobe went out the cycle before the answer
	task automatic bus_rd(input logic [7:0] a, output logic [7:0] d, output logic [7:0] oe,
			output logic st, output logic [7:0] bus);
		int i;
		logic ps;
		ps = 1'b0;
		st = 1'b0;
		d = 'x;
		oe = 'x;
		bus = 'x;
		cs <= 1'b1;
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		cs <= 1'b0;
		rd <= 1'b0;
		for (i = 0; i < 4; i++) begin
			#1;
			if (rv === 1'b1) begin
				d = hout;
				oe = hoe;
				bus = hbus;
				st = ps;
				break;
			end
			gcode = {s1e, s0e, s1e & s1o, s0e & s0o};
			ps = ste & sto;
			@(posedge clk);
		end
		@(posedge clk);
	endtask : bus_rd
	// group read started by the peer; st is the answer cycle's read-valid
	task automatic grp_rd(input logic [1:0] c, output logic [7:0] d, output logic [7:0] oe,
			output logic st);
		int i;
		d = 8'h00;
		oe = 8'h00;
		st = 1'b0;
		go <= 1'b1;
		pcode <= c;
		@(posedge clk);
		go <= 1'b0;
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			#1;
			if (hoe !== 8'h00) begin
				d = hout;
				oe = hoe;
				st = rv;
				break;
			end
		end
		@(posedge clk);
	endtask : grp_rd
	// status a member must show for a view, select code and line mode
	function automatic logic exp_st(input logic [1:0] v, input logic [2:0] c, input logic m);
		if (v == 2'h0) return irq;
		if (v == 2'h1) return sl;
		case (c)
			3'h0: return m ? al.unframed_all_ones : al.bit_oriented_code_seen;
			3'h1: return m ? al.remote_alarm : al.yellow_alarm;
			3'h2: return m ? al.distant_multiframe_alarm : al.loop_up_code;
			3'h3: return m ? al.v52_link_detect : al.loop_down_code;
			3'h4: return al.signaling_change;
			3'h5: return al.elastic_store_slip;
			default: return 1'b0;
		endcase
	endfunction : exp_st
	// watchdog well beyond the expected run of about 930 cycles
	initial begin
		#100000;
		n_mismatch++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end
	// reset, register defaults, view and code sweep, disabled member, unmapped address
	initial begin
		int k;
		logic [7:0] d, oe, bus;
		logic st, ex;
		logic [2:0] ln;
		nrst = 1'b0;
		{cs, rd, wr, go, e1, irq, sl, pst} = '0;
		{addr, wdata, line, pcode} = '0;
		al = '0;
		void'($urandom(3));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (k = 0; k < 3; k++) begin
			bus_rd(8'hB0 + 8'(k), d, oe, st, bus);
			cmp(d & oe, 8'h00);
		end
		$display("test reset values done");
		for (k = 0; k < 128; k++) begin
			ln = 3'($urandom());
			line <= ~ln;
			e1 <= k[5];
			irq <= 1'($urandom());
			sl <= 1'($urandom());
			pst <= 1'($urandom());
			al <= status_share_bus_pkg::alarm_in_t'(10'($urandom()));
			bus_wr(8'hB0, {4'h0, ln, 1'b1});
			bus_wr(8'hB1, {1'b0, ~k[4:2], 1'b0, k[4:2]});
			ex = exp_st(k[1:0], (k[1:0] == 2'h3) ? ~k[4:2] : k[4:2], k[5]);
			if (k[6]) begin
				grp_rd(k[1:0], d, oe, st);
				cmp({7'h00, st}, 8'h00);
			end else begin
				bus_rd(8'hB2 + 8'(k[1:0]), d, oe, st, bus);
				cmp({7'h00, st}, 8'h01);
				cmp({4'h0, gcode}, {6'h03, k[1:0]});
				cmp({7'h00, bus[~ln]}, {7'h00, pst});
			end
			cmp(oe, 8'h01 << ln);
			cmp(d & oe, {7'h00, ex} << ln);
		end
		$display("test view sweep done");
		bus_rd(8'hB1, d, oe, st, bus);
		cmp(d, 8'h07);
		bus_wr(8'hB0, 8'h0E);
		bus_rd(8'hB0, d, oe, st, bus);
		cmp(d, 8'h0E);
		bus_rd(8'hB2, d, oe, st, bus);
		cmp({7'h00, st}, 8'h00);
		cmp({4'h0, gcode}, 8'h00);
		grp_rd(2'h1, d, oe, st);
		cmp(oe, 8'h00);
		$display("test disabled member done");
		bus_rd(8'hB6, d, oe, st, bus);
		cmp(d & oe, 8'h00);
		$display("test unmapped read done");
		print_verdict();
	end
endmodule : status_share_bus_tb_top
`default_nettype wire
